/* codec_irq_pkg.sv */
// constants, register map and carrier types for the codec interrupt logic
package codec_irq_pkg;

  localparam int NREG   = 12;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int NFLAG  = NREG * DATA_W;

  // register map: status block, mask block, control
  localparam logic [1:0] STAT_PAGE = 2'h0;
  localparam logic [1:0] MASK_PAGE = 2'h1;
  localparam logic [5:0] CTRL_ADDR = 6'h20;

  // status register indices
  localparam int REG_TIP_DEB   = 0;
  localparam int REG_CAPT_OVF  = 1;
  localparam int REG_MIXER     = 2;
  localparam int REG_CONV      = 3;
  localparam int REG_PORT_RX   = 4;
  localparam int REG_PORT_TX   = 5;
  localparam int REG_GLOBAL    = 6;
  localparam int REG_HEADSET   = 7;
  localparam int REG_CONV_LOCK = 8;
  localparam int REG_SUPPLY    = 9;
  localparam int REG_SYNTH     = 10;
  localparam int REG_TIP_LEVEL = 11;

  // field positions used outside the plain byte mapping
  localparam int BIT_SHORT_DET = 6;
  localparam int BIT_RX_EARLY  = 3;
  localparam int BIT_RX_NOFRM  = 4;
  localparam int BIT_TX_FSM    = 0;

  // one-shot flags, flat index reg*8+bit, reg 11 in the top byte
  localparam logic [NFLAG-1:0] FLAG_ONESHOT = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                              8'h01, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00};

  // reset values
  localparam logic [7:0] MASK_RESET   = 8'hff;
  localparam logic [7:0] CTRL_RESET   = 8'h0c;
  localparam logic [7:0] RDATA_RESET  = 8'h00;
  localparam logic [3:0] LEVEL_RESET  = 4'h0;
  localparam logic       FLAG_RESET   = 1'b0;
  localparam logic       ARMED_RESET  = 1'b1;
  localparam logic       INT_N_RESET  = 1'b1;

  typedef enum logic [1:0] {
    DM_INACTIVE = 2'b00,
    DM_SHORT    = 2'b01,
    DM_SPARE    = 2'b10,
    DM_NORMAL   = 2'b11
  } detect_mode_t;

  typedef struct packed {
    logic [1:0]   spare;
    logic         digital_out_tx_off;
    logic         bias_current_sense_on;
    logic         mic_level_sense_off;
    logic         global_powerdown;
    detect_mode_t detect_mode;
  } ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  // event fields are one-cycle pulses, cond fields are levels
  typedef struct packed {
    logic [3:0] tip_deb_evt;     // tip_out, tip_in, ring_out, ring_in (bits 0..3)
    logic       capture_overflow_evt;
    logic [3:0] mixer_evt;       // biquad, equalizer, mix_a, mix_b
    logic [3:0] conv_cond;       // out_unlocked, in_unlocked, out_locked, in_locked
    logic [3:0] port_rx_evt;     // overload, error, late, early
    logic       port_rx_noframe_cond;
    logic [2:0] port_tx_evt;     // fsm_error, late, early
    logic       port_tx_noframe_cond;
    logic       headset_autodet_done_evt;
    logic       powerdown_done_cond;
    logic [6:0] headset_evt;     // bias, tip plug, tip unplug, fall, rise, release, short
    logic [1:0] conv_lock_cond;  // playback, capture
    logic       supply_monitor_trip_cond;
    logic       synth_lock_cond;
    logic [3:0] tip_ring_level;  // debounced levels tip_out, tip_in, ring_out, ring_in
    logic       rx_frame_valid;  // valid frame_clock transition seen on receive
    logic       tx_frame_rearm;  // valid frame clock or transmit overflow left
  } src_t;

endpackage

/* flag_cell.sv */
// one sticky read-to-clear status bit with optional one-shot arming
`timescale 1ns/1ps
module flag_cell
  import codec_irq_pkg::*;
#(
  parameter logic ONESHOT = 1'b0
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic src,
  input  wire logic rd_clr,
  input  wire logic pd_clr,
  input  wire logic rearm,
  output logic      q
);

  logic armed;

  // a one-shot source only fires while armed; its own read wins, so a lasting cause reads as 1 just once
  wire fire = src & (~ONESHOT | (armed & ~(rd_clr & q)));

  // set wins over read and power-down clear so no event is lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q     <= FLAG_RESET;
      armed <= ARMED_RESET;
    end else begin
      q <= fire | (q & ~rd_clr & ~pd_clr);
      if (rearm) begin
        armed <= 1'b1;
      end else if (rd_clr && q) begin
        armed <= 1'b0;
      end
    end
  end

  set_wins_a: assert property (@(posedge clk) disable iff (!nrst) fire |=> q)
    else $error("flag lost a set");
  oneshot_disarm_a: assert property (@(posedge clk) disable iff (!nrst)
      (ONESHOT && rd_clr && q && !rearm) |=> (!armed && !q))
    else $error("one-shot flag not disarmed after read");

endmodule

/* codec_irq_top.sv */
// interrupt status, mask and output logic of the audio codec
`timescale 1ns/1ps
//
// Contract
// - short-detect mode: only short detector drives interrupt
// - inactive or normal mode: any unmasked event interrupts
// - leftover flags may interrupt after short mode
// - powerdown clears all flags unless retain case
// - condition flag holds until read and gone, except the one-shot rx no-frame flag, which clears on its read
// - event flag clears on read
// - tip and ring debounce flags are events
// - overflow flags are events
// - serial port flag classes as listed
// - autodetect done event, powerdown done condition
// - all headset flags are events
// - converter lock flags are conditions
// - supply trip flag is a condition
// - synthesizer lock flag is a condition
// - tip ring level register reads live level
// - one-shot port flags read one once
// - one-shot flags rearm on frame clock, tx fsm flag also when transmit overflow left
// - interrupt holds until unmasked set flags read
// - mask hides interrupt but flag still records
module codec_irq_top
  import codec_irq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire bus_req_t          req,
  input  wire src_t              src,
  output logic [DATA_W-1:0]      rdata,
  output ctrl_t                  ctrl,
  output logic                   int_n
);

  logic [NFLAG-1:0]  status;
  logic [NFLAG-1:0]  mask;
  logic [3:0]        level_prev;
  logic [NFLAG-1:0]  flag_src;
  logic [NFLAG-1:0]  flag_rearm;
  logic [NREG-1:0]   stat_rd;

  // address decode
  wire [1:0]          page      = req.addr[5:4];
  wire [3:0]          idx       = req.addr[3:0];
  wire                idx_ok    = (32'(idx) < NREG);
  wire                stat_hit  = (page == STAT_PAGE) && idx_ok;
  wire                mask_hit  = (page == MASK_PAGE) && idx_ok;
  wire                ctrl_hit  = (req.addr == CTRL_ADDR);
  wire                ctrl_wr   = req.wr && ctrl_hit;
  wire ctrl_t         ctrl_new  = ctrl_t'(req.wdata);

  // tip/ring level changes become event flags, the read shows the level
  wire [3:0]          level_chg = src.tip_ring_level ^ level_prev;

  // source mapping; event sources are pulses, condition sources are levels
  always_comb begin
    flag_src = '0;
    flag_src[REG_TIP_DEB*8 +: 4]   = src.tip_deb_evt;
    flag_src[REG_CAPT_OVF*8]       = src.capture_overflow_evt;
    flag_src[REG_MIXER*8 +: 4]     = src.mixer_evt;
    flag_src[REG_CONV*8 +: 4]      = src.conv_cond;
    flag_src[REG_PORT_RX*8 +: 4]   = src.port_rx_evt;
    flag_src[REG_PORT_RX*8 + BIT_RX_NOFRM] = src.port_rx_noframe_cond;
    flag_src[REG_PORT_TX*8 +: 3]   = src.port_tx_evt;
    flag_src[REG_PORT_TX*8 + 3]    = src.port_tx_noframe_cond;
    flag_src[REG_GLOBAL*8]         = src.headset_autodet_done_evt;
    flag_src[REG_GLOBAL*8 + 1]     = src.powerdown_done_cond;
    flag_src[REG_HEADSET*8 +: 7]   = src.headset_evt;
    flag_src[REG_CONV_LOCK*8 +: 2] = src.conv_lock_cond;
    flag_src[REG_SUPPLY*8]         = src.supply_monitor_trip_cond;
    flag_src[REG_SYNTH*8]          = src.synth_lock_cond;
    flag_src[REG_TIP_LEVEL*8 +: 4] = level_chg;
  end

  // rearm paths for the one-shot port flags
  always_comb begin
    flag_rearm = '0;
    flag_rearm[REG_PORT_RX*8 + BIT_RX_EARLY] = src.rx_frame_valid;
    flag_rearm[REG_PORT_RX*8 + BIT_RX_NOFRM] = src.rx_frame_valid;
    flag_rearm[REG_PORT_TX*8 + BIT_TX_FSM]   = src.tx_frame_rearm;
  end

  // interrupt request selection
  wire [NFLAG-1:0] unmasked  = status & ~mask;
  wire             any_set   = |status;
  wire             short_req = unmasked[REG_HEADSET*8 + BIT_SHORT_DET];
  wire             is_short  = (ctrl.detect_mode == DM_SHORT);
  wire             int_req   = is_short ? short_req : |unmasked;

  // power-down clear, kept back while sensing stays alive with a pending flag
  wire retain   = (~ctrl.mic_level_sense_off | ctrl.bias_current_sense_on) &&
                  (ctrl.detect_mode != DM_INACTIVE) && any_set;
  wire pd_rise  = ctrl_wr && ctrl_new.global_powerdown && !ctrl.global_powerdown;
  wire pd_exit  = ctrl_wr && ctrl.global_powerdown && ctrl_new.global_powerdown &&
                  (ctrl_new.detect_mode == DM_INACTIVE) && retain;
  wire pd_clr   = (pd_rise && !retain) || pd_exit;

  // per-register read strobe; clearing after the read keeps the old value visible
  genvar r;
  generate
    for (r = 0; r < NREG; r++) begin : g_rd
      assign stat_rd[r] = req.rd && stat_hit && (32'(idx) == r);
    end
  endgenerate

  // one sticky cell per status bit
  genvar f;
  generate
    for (f = 0; f < NFLAG; f++) begin : g_flag
      flag_cell #(
        .ONESHOT (FLAG_ONESHOT[f])
      ) u_flag (
        .clk    (clk),
        .nrst   (nrst),
        .src    (flag_src[f]),
        .rd_clr (stat_rd[f / 8]),
        .pd_clr (pd_clr),
        .rearm  (flag_rearm[f]),
        .q      (status[f])
      );
    end
  endgenerate

  // read data selection
  wire [DATA_W-1:0] stat_byte  = status[idx*8 +: 8];
  wire [DATA_W-1:0] mask_byte  = mask[idx*8 +: 8];
  wire              level_rd   = (32'(idx) == REG_TIP_LEVEL);
  wire [DATA_W-1:0] level_byte = {4'h0, src.tip_ring_level};
  wire [DATA_W-1:0] next_rdata = !req.rd   ? RDATA_RESET :
                                 stat_hit  ? (level_rd ? level_byte : stat_byte) :
                                 mask_hit  ? mask_byte :
                                 ctrl_hit  ? DATA_W'(ctrl) : RDATA_RESET;

  // mask registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask <= {NREG{MASK_RESET}};
    end else if (req.wr && mask_hit) begin
      mask[idx*8 +: 8] <= req.wdata;
    end
  end

  // control register; mode, power-down and sense enables steer the clear logic
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= ctrl_t'(CTRL_RESET);
    end else if (ctrl_wr) begin
      ctrl <= ctrl_new;
    end
  end

  // level history for change detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_prev <= LEVEL_RESET;
    end else begin
      level_prev <= src.tip_ring_level;
    end
  end

  // registered outputs; read data stands one cycle only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= RDATA_RESET;
      int_n <= INT_N_RESET;
    end else begin
      rdata <= next_rdata;
      int_n <= ~int_req;
    end
  end

  short_only_a: assert property (@(posedge clk) disable iff (!nrst)
      (is_short && !short_req) |=> int_n)
    else $error("interrupt raised by a non-short source in short mode");

  normal_int_a: assert property (@(posedge clk) disable iff (!nrst)
      (!is_short && (|unmasked)) |=> !int_n)
    else $error("unmasked flag did not raise interrupt");

  short_exit_a: assert property (@(posedge clk) disable iff (!nrst)
      ($past(is_short) && ctrl.detect_mode == DM_NORMAL && (|unmasked)) |=> !int_n)
    else $error("leftover flag ignored after short mode");

  pd_clear_a: assert property (@(posedge clk) disable iff (!nrst)
      (pd_clr && !(|flag_src)) |=> (status == '0))
    else $error("power-down did not clear flags");

  event_clear_a: assert property (@(posedge clk) disable iff (!nrst)
      (stat_rd[REG_CAPT_OVF] && !src.capture_overflow_evt) |=> !status[REG_CAPT_OVF*8])
    else $error("event flag survived its read");

  cond_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      src.supply_monitor_trip_cond [*2] |-> status[REG_SUPPLY*8])
    else $error("condition flag dropped while present");

  level_read_a: assert property (@(posedge clk) disable iff (!nrst)
      stat_rd[REG_TIP_LEVEL] |=> (rdata == {4'h0, $past(src.tip_ring_level)}))
    else $error("level register did not return live level");

  masked_record_a: assert property (@(posedge clk) disable iff (!nrst)
      (src.mixer_evt[0] && mask[REG_MIXER*8]) |=> status[REG_MIXER*8])
    else $error("masked event not recorded");

  int_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (!int_n && $past(!(|stat_rd) && !pd_clr && !ctrl_wr && !(req.wr && mask_hit))) |=> !int_n)
    else $error("interrupt released before flags read");

endmodule

/* irq_host.sv */
// host side model: counts the interrupt requests it is asked to service
`timescale 1ns/1ps
module irq_host
  import codec_irq_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   nrst,
  input  wire logic   int_n,
  output logic [15:0] falls
);
  logic last_n;
  // a request is a high-to-low step of the active-low line
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_n <= 1'b1;
      falls  <= 16'h0000;
    end else begin
      last_n <= int_n;
      if (last_n && !int_n) falls <= falls + 16'h0001;
    end
  end
endmodule

/* codec_irq_top_tb.sv */
// self-checking bench for the codec interrupt logic
`timescale 1ns/1ps
module codec_irq_top_tb
  import codec_irq_pkg::*;
;
  logic       clk, nrst, int_n, prev, held, armed, tarmed;
  bus_req_t   req;
  src_t       src;
  ctrl_t      ctrl;
  logic [7:0] rdata, mctrl, mstat[12], mlev[12], mmask[12];
  logic [15:0] falls, mfalls;
  int         err_total, n_tests, a, b;
  // event bits and condition bits of status registers 0 to 10, without the one-shot bits
  logic [7:0] evm[8] = '{8'h0f, 8'h01, 8'h0f, 8'h00, 8'h07, 8'h06, 8'h01, 8'h7f};
  logic [7:0] cdm[11] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h08, 8'h02, 8'h00, 8'h03, 8'h01, 8'h01};

  codec_irq_top codec_irq_top_inst (.clk(clk), .nrst(nrst), .req(req), .src(src), .rdata(rdata), .ctrl(ctrl),
                                    .int_n(int_n));
  irq_host irq_host_inst (.clk(clk), .nrst(nrst), .int_n(int_n), .falls(falls));

  always #20 clk = ~clk;

  task finish_test();
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk8(logic [7:0] g, logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask

  task chk1(logic g, logic e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t int_n %b expected %b", $time, g, e);
    end
  endtask

  // um=1: only unmasked flags count
  function automatic logic flags(logic um);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 12; i++) r |= |(mstat[i] & ~(um ? mmask[i] : 8'h00));
    return r;
  endfunction

  function automatic logic exp_int();
    if (mctrl[1:0] == 2'b01) return mstat[7][6] & ~mmask[7][6];
    return flags(1'b1);
  endfunction

  function automatic logic [7:0] reg_exp(int a);
    if (a < 11) return mstat[a];
    if (a == 11) return {4'h0, mlev[11][3:0]};
    if (a >= 16 && a < 28) return mmask[a-16];
    if (a == 32) return mctrl;
    return 8'h00;
  endfunction

  function automatic src_t put(src_t s, int a, int b, logic v);
    case (a)
      0: s.tip_deb_evt[b] = v;
      1: s.capture_overflow_evt = v;
      2: s.mixer_evt[b] = v;
      3: s.conv_cond[b] = v;
      4: s.port_rx_evt[b] = v;
      5: if (b == 3) s.port_tx_noframe_cond = v; else s.port_tx_evt[b] = v;
      6: if (b == 0) s.headset_autodet_done_evt = v; else s.powerdown_done_cond = v;
      7: s.headset_evt[b] = v;
      8: s.conv_lock_cond[b] = v;
      9: s.supply_monitor_trip_cond = v;
      10: s.synth_lock_cond = v;
      11: s.tip_ring_level[b] = v;
      12: s.rx_frame_valid = v;
      default: s.tx_frame_rearm = v;
    endcase
    return s;
  endfunction

  // interrupt line settles two edges after any cause
  task ck_int();
    logic e;
    repeat (2) @(posedge clk);
    #1 e = exp_int();
    if (e && !prev) mfalls++;
    prev = e;
    chk1(int_n, !e);
  endtask

  // pls: one-cycle event pulse, else a held level
  task src_op(int a, int b, logic v, logic pls);
    @(posedge clk);
    src <= put(src, a, b, v);
    if (pls) begin
      @(posedge clk);
      src <= put(src, a, b, 1'b0);
    end
    if (a == 12) armed = 1'b1;
    else if (a == 13) tarmed = 1'b1;
    else begin
      if (a == 11 ? mlev[11][b] != v : v && !(a == 4 && b == 3 && !armed) && !(a == 5 && b == 0 && !tarmed))
        mstat[a][b] = 1'b1;
      if (!pls) mlev[a][b] = v;
    end
    ck_int();
  endtask

  task rd(int a);
    logic [7:0] e;
    e = reg_exp(a);
    @(posedge clk);
    req <= '{addr: 6'(a), wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk8(rdata, e);
    if (a < 12) begin
      if (a == 4 && e[3]) armed = 1'b0;
      if (a == 5 && e[0]) tarmed = 1'b0;
      mstat[a] = (a == 11) ? 8'h00 : mlev[a];
    end
    ck_int();
  endtask

  task wr(int a, logic [7:0] d);
    @(posedge clk);
    req <= '{addr: 6'(a), wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    if (a >= 16 && a < 28) mmask[a-16] = d;
    if (a == 32) begin
      if (d[2] && (!mctrl[2] || held)) begin
        held = (!d[3] || d[4]) && d[1:0] != 2'b00 && flags(1'b0);
        if (!held) mstat = '{default: 8'h00};
      end
      if (!d[2]) held = 1'b0;
      mctrl = d;
    end
    ck_int();
    chk8(ctrl, mctrl);
  endtask

  // watchdog: whole run needs well under 10000 cycles
  initial begin
    #400000;
    err_total++;
    finish_test();
  end

  initial begin
    clk = 1'b0; nrst = 1'b0; req = '0; src = '0; prev = 1'b0; held = 1'b0; armed = 1'b1; tarmed = 1'b1;
    err_total = 0; n_tests = 0; mfalls = 16'h0000; mctrl = CTRL_RESET;
    mstat = '{default: 8'h00}; mlev = '{default: 8'h00}; mmask = '{default: 8'hff};
    void'($urandom(32'h01bb2efb));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(32); rd(16); rd(63);
    wr(32, 8'h2c);
    for (a = 0; a < 12; a++) wr(16 + a, 8'h00);
    wr(32, 8'h08);
    for (a = 0; a < 8; a++) for (b = 0; b < 8; b++) if (evm[a][b]) begin
      src_op(a, b, 1'b1, 1'b1); rd(a); rd(a);
    end
    for (a = 0; a < 11; a++) for (b = 0; b < 8; b++) if (cdm[a][b]) begin
      src_op(a, b, 1'b1, 1'b0); rd(a); rd(a);
      src_op(a, b, 1'b0, 1'b0); rd(a); rd(a);
    end
    wr(32, 8'h0b);
    wr(18, 8'($urandom) | 8'h01);
    for (b = 0; b < 4; b++) src_op(2, b, 1'b1, 1'b1);
    src_op(1, 0, 1'b1, 1'b1); wr(18, 8'h00); rd(1); rd(2);
    wr(32, 8'h09); src_op(2, 0, 1'b1, 1'b1); src_op(7, 6, 1'b1, 1'b1); rd(7);
    wr(32, 8'h0b); rd(2);
    wr(32, 8'h09); src_op(2, 1, 1'b1, 1'b1); rd(2); wr(32, 8'h0b);
    src_op(4, 3, 1'b1, 1'b1); rd(4); src_op(4, 3, 1'b1, 1'b1); rd(4);
    src_op(12, 0, 1'b1, 1'b1); src_op(4, 3, 1'b1, 1'b1); rd(4);
    src_op(5, 0, 1'b1, 1'b1); rd(5); src_op(5, 0, 1'b1, 1'b1); rd(5);
    src_op(13, 0, 1'b1, 1'b1); src_op(5, 0, 1'b1, 1'b1); rd(5);
    repeat (4) begin
      b = $urandom_range(3, 0);
      src_op(11, b, ~mlev[11][b], 1'b0); rd(11);
    end
    wr(32, 8'h08); src_op(2, 0, 1'b1, 1'b1); wr(32, 8'h0c); rd(2);
    wr(32, 8'h03); src_op(2, 0, 1'b1, 1'b1); wr(32, 8'h07);
    wr(32, 8'h04); rd(2);
    wr(63, 8'hff); rd(32); rd(47);
    chk8(falls[7:0], mfalls[7:0]);
    finish_test();
  end
endmodule
